// file: include/chg_pkg.sv
/*
 * Shared constants for the charger control core: command codes,
 * register reset values, mode bit positions, status bit positions.
 * Assumes an SMBus slave front end that delivers decoded word writes.
 */
`default_nettype none
package chg_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_MODE = 8'h12;
	localparam logic [7:0] CMD_STATUS = 8'h13;
	localparam logic [7:0] CMD_CURRENT = 8'h14;
	localparam logic [7:0] CMD_VOLTAGE = 8'h15;
	localparam logic [7:0] CMD_ALARM = 8'h16;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
	localparam logic [7:0] ALERT_RESP_ADDR8 = 8'h19;
	localparam logic [7:0] ALERT_RESP_BYTE = 8'h89;
	// ------------------------------------------------------------
	// Reset values and thresholds
	// ------------------------------------------------------------
	localparam logic [15:0] CURRENT_RESET = 16'h000C;
	localparam logic [15:0] VOLTAGE_RESET = 16'hFFF0;
	localparam logic [15:0] VOLTAGE_MIN = 16'h0010;
	localparam logic [15:0] CURRENT_POR_CMD = 16'h00C0;
	localparam logic [15:0] VOLTAGE_POR_CMD = 16'hFFFF;
	localparam logic [15:0] LOW_FULL = 16'h03FF;
	localparam logic [15:0] OPEN_FULL = 16'h07FF;
	localparam logic [15:0] HIGH_FULL = 16'h0FFF;
	localparam logic [5:0] CODE_SAT_LOW = 6'h3E;
	localparam logic [5:0] CODE_SAT = 6'h3F;
	localparam logic [4:0] TRICKLE_FULL = 5'h1F;
	// ------------------------------------------------------------
	// Mode word bits
	// ------------------------------------------------------------
	localparam int MODE_INHIBIT = 0;
	localparam int MODE_POR = 2;
	localparam int MODE_BP_MASK = 5;
	localparam int MODE_PF_MASK = 6;
	localparam int MODE_OVERTEMP_SHUTDOWN_EN = 10;
	localparam logic MODE_BP_MASK_RST = 1'b0;
	localparam logic MODE_PF_MASK_RST = 1'b1;
	localparam logic MODE_OVERTEMP_SHUTDOWN_EN_RST = 1'b1;
	// ------------------------------------------------------------
	// Status word bits
	// ------------------------------------------------------------
	localparam int ST_INHIBIT = 0;
	localparam int ST_LEVEL2 = 4;
	localparam int ST_CURRENT_OR = 5;
	localparam int ST_VOLTAGE_OR = 6;
	localparam int ST_ALARM = 7;
	localparam int ST_THERM_UR = 10;
	localparam int ST_THERM_HOT = 12;
	localparam int ST_POWER_FAIL = 13;
	localparam int ST_BATT_PRESENT = 14;
	// ------------------------------------------------------------
	// Range strap and timing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RANGE_LOW = 2'h0,
		RANGE_OPEN = 2'h1,
		RANGE_HIGH = 2'h2
	} range_t;
	localparam int CLK_HZ = 20000000;
endpackage
`default_nettype wire

// file: rtl/charger_current_alarm_control.sv
/*
 * Charger control core: current command decode, alarm latch, status word,
 * and host alert. Assumes an SMBus slave delivers one-cycle word-write and
 * read strobes on clk_i; analog status inputs and the strap are asynchronous.
 */
// Summary of operation
// - Switcher current is set by a six-bit code, bits five down to zero.
// - Regulator off holds high gate at switch node, low gate at ground.
// - Words 0x0000 to 0x001F give code zero, regulator off; larger words on.
// - Code bits come from D9..D5, D10..D5 or D11..D6 per range strap.
// - In high range, D5 set forces code bit zero to one.
// - Over-range words saturate the code (62 low, 63 else) and flag it.
// - Inhibit, alarm or over-temperature turns regulator off, code unchanged.
// - Any nonzero code drives trickle source to full scale unless inhibit, alarm, over-temperature or low voltage holds it off.
// - Command bits D4..D0 weight the trickle source.
// - Current register powers on at 0x000C, twelve milliamp trickle.
// - Battery absent returns the current register to its power-on value.
// - Alarm command is a word write with code 0x16.
// - Alarm write with D15, D14 or D12 set latches alarm inhibit.
// - Alarm inhibit holds until battery absent or mode reset request.
// - Alarm inhibit keeps regulator and trickle source off.
// - Status is a word read at code 0x13 returning sixteen bits.
// - Alert pulls low on power applied, battery-present or power-fail change.
// - Battery-present and power-fail alerts each have a mask bit.
// - Alert stays low until cleared.
// - Alert clears by status read or alert-response receive byte.
// - Alert-response receive byte returns 0x89.
// - Mode reset request clears hot and alarm latches, sets current to 0x00C0 and voltage to 0xFFFF.
// - Battery mask is mode bit 5 reset 0, power-fail mask bit 6 reset 1.
`default_nettype none
module charger_current_alarm_control
	import chg_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic wr_stb_i,
	input wire logic [7:0] wr_cmd_i,
	input wire logic [15:0] wr_data_i,
	input wire logic status_rd_i,
	input wire logic ara_rd_i,
	input wire logic [1:0] range_strap_i,
	input wire logic batt_present_i,
	input wire logic power_fail_i,
	input wire logic input_supply_pin_i,
	input wire logic therm_hot_i,
	input wire logic therm_underrange_i,
	input wire logic [15:0] analog_status_i,
	output logic [5:0] switcher_current_code_o,
	output logic [4:0] trickle_weight_bits_o,
	output logic switcher_on_o,
	output logic high_side_gate_o,
	output logic low_side_gate_o,
	output logic [15:0] status_word_o,
	output logic [7:0] ara_byte_o,
	output logic alert_n_o
);
	// ------------------------------------------------------------
	// Pin synchronisers (analog comparators and strap are asynchronous)
	// ------------------------------------------------------------
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic [15:0] ana1;
	logic [15:0] ana2;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
			ana1 <= 16'h0000;
			ana2 <= 16'h0000;
		end else if (ce_i) begin
			sync1 <= {range_strap_i, batt_present_i, power_fail_i, input_supply_pin_i,
				therm_hot_i, therm_underrange_i};
			sync2 <= sync1;
			ana1 <= analog_status_i;
			ana2 <= ana1;
		end
	end
	wire logic [1:0] strap = sync2[6:5];
	wire logic batt_ok = sync2[4];
	wire logic pfail = sync2[3];
	wire logic supply = sync2[2];
	wire logic hot_raw = sync2[1];
	wire logic therm_ur = sync2[0];

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire logic wr_mode = wr_stb_i && (wr_cmd_i == CMD_MODE);
	wire logic wr_cur = wr_stb_i && (wr_cmd_i == CMD_CURRENT);
	wire logic wr_volt = wr_stb_i && (wr_cmd_i == CMD_VOLTAGE);
	wire logic wr_alarm = wr_stb_i && (wr_cmd_i == CMD_ALARM);
	wire logic por_req = wr_mode && wr_data_i[MODE_POR];

	// Mode bits kept by this core; reset request is a strobe, not stored
	logic charge_off_flag;
	logic bp_mask;
	logic pf_mask;
	logic overtemp_shutdown_en;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			charge_off_flag <= 1'b0;
			bp_mask <= MODE_BP_MASK_RST;
			pf_mask <= MODE_PF_MASK_RST;
			overtemp_shutdown_en <= MODE_OVERTEMP_SHUTDOWN_EN_RST;
		end else if (ce_i && wr_mode) begin
			charge_off_flag <= wr_data_i[MODE_INHIBIT];
			bp_mask <= wr_data_i[MODE_BP_MASK];
			pf_mask <= wr_data_i[MODE_PF_MASK];
			overtemp_shutdown_en <= wr_data_i[MODE_OVERTEMP_SHUTDOWN_EN];
		end
	end

	// Setpoint registers; battery removal restores power-on values
	logic [15:0] cur_set;
	logic [15:0] volt_set;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur_set <= CURRENT_RESET;
			volt_set <= VOLTAGE_RESET;
		end else if (ce_i) begin
			if (!batt_ok) begin
				cur_set <= CURRENT_RESET;
				volt_set <= VOLTAGE_RESET;
			end else if (por_req) begin
				cur_set <= CURRENT_POR_CMD;
				volt_set <= VOLTAGE_POR_CMD;
			end else begin
				if (wr_cur)
					cur_set <= wr_data_i;
				if (wr_volt)
					volt_set <= wr_data_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Latched alarm inhibit and therm_over_temp
	// ------------------------------------------------------------
	logic alarm_inhibit_latch;
	logic therm_over_temp;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			alarm_inhibit_latch <= 1'b0;
			therm_over_temp <= 1'b0;
		end else if (ce_i) begin
			// Set beats clear so an alarm in the clearing cycle is kept
			if (wr_alarm && (wr_data_i[15] || wr_data_i[14] || wr_data_i[12]))
				alarm_inhibit_latch <= 1'b1;
			else if (!batt_ok || por_req)
				alarm_inhibit_latch <= 1'b0;
			if (hot_raw)
				therm_over_temp <= 1'b1;
			else if (!batt_ok || por_req)
				therm_over_temp <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Current code decode
	// ------------------------------------------------------------
	// Returns code with bit 6 as the over-range flag
	function automatic logic [6:0] decode_code(input logic [15:0] w, input logic [1:0] r);
		logic [5:0] c;
		logic ovr;
		c = 6'h00;
		ovr = 1'b0;
		case (r)
			RANGE_LOW: begin
				ovr = (w > LOW_FULL);
				c = ovr ? CODE_SAT_LOW : {w[9:5], 1'b0};
			end
			RANGE_HIGH: begin
				ovr = (w > HIGH_FULL);
				c = ovr ? CODE_SAT : {w[11:7], w[6] | w[5]};
			end
			default: begin
				ovr = (w > OPEN_FULL);
				c = ovr ? CODE_SAT : w[10:5];
			end
		endcase
		return {ovr, c};
	endfunction

	wire logic [6:0] dec = decode_code(cur_set, strap);
	wire logic over_temp = therm_over_temp && overtemp_shutdown_en && !therm_ur;
	wire logic hold = charge_off_flag || alarm_inhibit_latch || over_temp
		|| (volt_set < VOLTAGE_MIN);

	logic current_or;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			switcher_current_code_o <= 6'h00;
			current_or <= 1'b0;
			switcher_on_o <= 1'b0;
		end else if (ce_i) begin
			switcher_on_o <= !hold && (dec[5:0] != 6'h00);
			if (!hold) begin
				switcher_current_code_o <= dec[5:0];
				current_or <= dec[6];
			end
		end
	end

	// Gate drive follows regulator state: off means high to switch node, low grounded
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			high_side_gate_o <= 1'b0;
			low_side_gate_o <= 1'b0;
		end else if (ce_i) begin
			high_side_gate_o <= !hold && (dec[5:0] != 6'h00);
			low_side_gate_o <= !hold && (dec[5:0] != 6'h00);
		end
	end

	// Trickle weight; zero in hold, else full scale whenever a code bit is set
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			trickle_weight_bits_o <= 5'h00;
		else if (ce_i) begin
			if (alarm_inhibit_latch || charge_off_flag || over_temp
				|| (volt_set < VOLTAGE_MIN))
				trickle_weight_bits_o <= 5'h00;
			else if (dec[5:0] != 6'h00)
				trickle_weight_bits_o <= TRICKLE_FULL;
			else
				trickle_weight_bits_o <= cur_set[4:0];
		end
	end

	// ------------------------------------------------------------
	// Status word and alert
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			status_word_o <= 16'h0000;
			ara_byte_o <= 8'h00;
		end else if (ce_i) begin
			status_word_o <= (ana2 & 16'h8B0C)
				| (16'h0001 << ST_LEVEL2)
				| ({15'h0000, charge_off_flag} << ST_INHIBIT)
				| ({15'h0000, current_or} << ST_CURRENT_OR)
				| ({15'h0000, volt_set[15] | volt_set[14]} << ST_VOLTAGE_OR)
				| ({15'h0000, alarm_inhibit_latch} << ST_ALARM)
				| ({15'h0000, therm_ur} << ST_THERM_UR)
				| ({15'h0000, therm_over_temp} << ST_THERM_HOT)
				| ({15'h0000, pfail} << ST_POWER_FAIL)
				| ({15'h0000, batt_ok} << ST_BATT_PRESENT);
			ara_byte_o <= ALERT_RESP_BYTE;
		end
	end

	logic bp_d;
	logic pf_d;
	logic sup_d;
	wire logic alert_evt = (supply && !sup_d) || ((bp_d != batt_ok) && !bp_mask)
		|| ((pf_d != pfail) && !pf_mask);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bp_d <= 1'b0;
			pf_d <= 1'b0;
			sup_d <= 1'b0;
			alert_n_o <= 1'b1;
		end else if (ce_i) begin
			bp_d <= batt_ok;
			pf_d <= pfail;
			sup_d <= supply;
			// New event wins over a clear in the same cycle
			if (alert_evt)
				alert_n_o <= 1'b0;
			else if (status_rd_i || ara_rd_i)
				alert_n_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_alarm_set;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && wr_alarm && wr_data_i[12]) |=> alarm_inhibit_latch;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched");
	property p_alarm_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && alarm_inhibit_latch) |=> (!switcher_on_o && trickle_weight_bits_o == 5'h00);
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("output on in alarm");
	property p_batt_reset;
		@(posedge clk_i) disable iff (sys_rst_i)
		// An alarm write in the removal cycle wins, so it is left out here
		(ce_i && !batt_ok && !(wr_alarm && (wr_data_i[15] || wr_data_i[14] || wr_data_i[12])))
			|=> (cur_set == CURRENT_RESET && !alarm_inhibit_latch);
	endproperty
	a_batt_reset: assert property (p_batt_reset) else $error("no reset on removal");
	property p_full_trickle;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && !hold && dec[5:0] != 6'h00) |=> trickle_weight_bits_o == TRICKLE_FULL;
	endproperty
	a_full_trickle: assert property (p_full_trickle) else $error("trickle not full");
	sequence s_evt;
		ce_i && alert_evt;
	endsequence
	property p_alert_low;
		@(posedge clk_i) disable iff (sys_rst_i)
		s_evt |=> !alert_n_o;
	endproperty
	a_alert_low: assert property (p_alert_low) else $error("alert not low");
	property p_alert_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!alert_n_o && !(ce_i && (status_rd_i || ara_rd_i))) |=> !alert_n_o;
	endproperty
	a_alert_hold: assert property (p_alert_hold) else $error("alert released early");
	property p_hold_code;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && hold) |=> (!switcher_on_o && $stable(switcher_current_code_o));
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code moved in hold");
	property p_gate_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ce_i && (hold || dec[5:0] == 6'h00)) |=> (!high_side_gate_o && !low_side_gate_o);
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gate active while off");
endmodule
`default_nettype wire

// file: testbench/charger_current_alarm_control_tb_top.sv
/*
 * Self-checking bench for the charger control core: current decode,
 * holds, alarm latch and host alert. Assumes chg_pkg and the host model.
 */
`default_nettype none
module charger_current_alarm_control_tb_top;
	import chg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, batt = 1'b1, pfail = 1'b0, supply = 1'b0, hot = 1'b0;
	logic [1:0] strap = 2'h1;
	logic stb, srd, ard, on, hg, lg, alert_n;
	logic [7:0] cmd, ara;
	logic [15:0] data, st;
	logic [5:0] code;
	logic [4:0] trk;
	int err_total = 0, checked = 0;
	// Mode word keeping reset masks: power-fail mask and overtemp_shutdown_en set
	localparam logic [15:0] MODE_BASE = 16'h0440;
	// ------------------------------------------------------------
	// Clock, partner and core
	// ------------------------------------------------------------
	// 20 MHz core clock
	always #25 clk = ~clk;
	chg_host_model host (.clk_i(clk), .wr_stb_o(stb), .wr_cmd_o(cmd), .wr_data_o(data),
		.status_rd_o(srd), .ara_rd_o(ard));
	charger_current_alarm_control dut (.clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1),
		.wr_stb_i(stb), .wr_cmd_i(cmd), .wr_data_i(data), .status_rd_i(srd),
		.ara_rd_i(ard), .range_strap_i(strap), .batt_present_i(batt),
		.power_fail_i(pfail), .input_supply_pin_i(supply), .therm_hot_i(hot),
		.therm_underrange_i(1'b0), .analog_status_i(16'h0000),
		.switcher_current_code_o(code), .trickle_weight_bits_o(trk), .switcher_on_o(on),
		.high_side_gate_o(hg), .low_side_gate_o(lg), .status_word_o(st),
		.ara_byte_o(ara), .alert_n_o(alert_n));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("code", 16'h0000, code);
		chk("trickle", 16'h000C, trk);
		chk("on", 16'h0000, on);
		chk("ara", 16'h0089, ara);
		chk("batt_bit", 16'h0001, st[ST_BATT_PRESENT]);
		chk("level2_bit", 16'h0001, st[ST_LEVEL2]);
	endtask
	// Range boundaries per strap; over-range entries followed by in-range ones
	task automatic t_ranges();
		logic [1:0] s[12] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2};
		logic [15:0] w[12] = '{16'h001F, 16'h0400, 16'h0020, 16'h03FF, 16'h0020, 16'h0800,
			16'h07FF, 16'h0000, 16'h0020, 16'h0040, 16'h1000, 16'h0FFF};
		logic [5:0] c[12] = '{0, 62, 2, 62, 1, 63, 63, 0, 1, 1, 63, 63};
		logic [11:0] ovr = 12'b0100_0100_0010;
		logic e;
		for (int i = 0; i < 12; i++) begin
			strap = s[i];
			settle(4);
			host.write_word(CMD_CURRENT, w[i]);
			settle(2);
			e = c[i] != 6'h00;
			chk("code", c[i], code);
			chk("on", e, on);
			chk("high_gate", e, hg);
			chk("low_gate", e, lg);
			chk("trickle", e ? 16'h001F : w[i][4:0], trk);
			chk("over_bit", ovr[11 - i], st[ST_CURRENT_OR]);
		end
	endtask
	// Low voltage and inhibit freeze the code with the regulator off; over-temperature keeps it off until a mode reset request
	task automatic t_hold();
		strap = 2'h1;
		host.write_word(CMD_CURRENT, 16'h0040);
		host.write_word(CMD_VOLTAGE, 16'h000F);
		host.write_word(CMD_CURRENT, 16'h07FF);
		settle(2);
		chk("code", 16'h0002, code);
		chk("on", 16'h0000, on);
		host.write_word(CMD_MODE, MODE_BASE | 16'h0001);
		host.write_word(CMD_VOLTAGE, 16'hFFF0);
		host.write_word(CMD_CURRENT, 16'h0040);
		settle(2);
		chk("code", 16'h0002, code);
		chk("on", 16'h0000, on);
		host.write_word(CMD_MODE, MODE_BASE);
		host.write_word(CMD_CURRENT, 16'h07FF);
		hot = 1'b1;
		settle(4);
		chk("on", 16'h0000, on);
		hot = 1'b0;
		settle(4);
		chk("on", 16'h0000, on);
		chk("hot_bit", 16'h0001, st[ST_THERM_HOT]);
		host.write_word(CMD_MODE, MODE_BASE | 16'h0004);
		settle(2);
		chk("hot_bit", 16'h0000, st[ST_THERM_HOT]);
		chk("code", 16'h0006, code);
		chk("on", 16'h0001, on);
	endtask
	// Alarm latch from each of its three data bits, and both ways it is cleared
	task automatic t_alarm();
		int b[3] = '{15, 14, 12};
		host.write_word(CMD_ALARM, 16'h2FFF);
		settle(2);
		chk("alarm_bit", 16'h0000, st[ST_ALARM]);
		for (int i = 0; i < 3; i++) begin
			host.write_word(CMD_ALARM, 16'h0001 << b[i]);
			host.write_word(CMD_CURRENT, 16'h0040);
			settle(2);
			chk("alarm_bit", 16'h0001, st[ST_ALARM]);
			chk("on", 16'h0000, on);
			chk("trickle", 16'h0000, trk);
			if (i < 2) begin
				host.write_word(CMD_MODE, MODE_BASE | 16'h0004);
				settle(2);
				chk("alarm_bit", 16'h0000, st[ST_ALARM]);
			end
		end
		batt = 1'b0;
		settle(4);
		host.write_word(CMD_CURRENT, 16'h0800);
		settle(2);
		chk("alarm_bit", 16'h0000, st[ST_ALARM]);
		chk("code", 16'h0000, code);
		chk("trickle", 16'h000C, trk);
		batt = 1'b1;
		settle(4);
	endtask
	// Alert sources, masks and both clearing transactions
	task automatic t_alert();
		host.read_status();
		settle(2);
		chk("alert_n", 16'h0001, alert_n);
		supply = 1'b1;
		settle(4);
		chk("alert_n", 16'h0000, alert_n);
		settle(8);
		chk("alert_n", 16'h0000, alert_n);
		host.read_status();
		settle(2);
		chk("alert_n", 16'h0001, alert_n);
		batt = 1'b0;
		settle(4);
		chk("alert_n", 16'h0000, alert_n);
		host.read_ara();
		settle(2);
		chk("alert_n", 16'h0001, alert_n);
		batt = 1'b1;
		settle(4);
		host.read_ara();
		settle(2);
		chk("alert_n", 16'h0001, alert_n);
		// Power-fail mask is set out of reset, so this change must stay quiet
		pfail = 1'b1;
		settle(4);
		chk("alert_n", 16'h0001, alert_n);
		host.write_word(CMD_MODE, 16'h0420);
		pfail = 1'b0;
		settle(4);
		chk("alert_n", 16'h0000, alert_n);
		host.read_status();
		batt = 1'b0;
		settle(4);
		chk("alert_n", 16'h0001, alert_n);
		batt = 1'b1;
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	// Reset for eight cycles, then every scenario in turn
	initial begin
		settle(8);
		rst = 1'b0;
		settle(4);
		t_reset();
		t_ranges();
		t_hold();
		t_alarm();
		t_alert();
		close_out();
	end
	// Run needs well under 2000 cycles; ten times that means a hang
	initial begin
		#(20000 * 50);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire

// file: testbench/chg_host_model.sv
/*
 * Host controller model: issues word writes, status reads and
 * alert-response reads as one-cycle strobes on the core clock.
 * Assumes the bench calls its tasks and shares clk_i with the core.
 */
`default_nettype none
module chg_host_model (
	input wire logic clk_i,
	output logic wr_stb_o,
	output logic [7:0] wr_cmd_o,
	output logic [15:0] wr_data_o,
	output logic status_rd_o,
	output logic ara_rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	// Idle strobes low from time zero
	initial begin
		wr_stb_o = 1'b0;
		wr_cmd_o = 8'h00;
		wr_data_o = 16'h0000;
		status_rd_o = 1'b0;
		ara_rd_o = 1'b0;
	end
	// Word write; command and data scrambled after release so stale values never match
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
		@(posedge clk_i);
		#1;
		wr_stb_o = 1'b1;
		wr_cmd_o = cmd;
		wr_data_o = data;
		@(posedge clk_i);
		#1;
		wr_stb_o = 1'b0;
		wr_cmd_o = ~cmd;
		wr_data_o = ~data;
	endtask
	// Status word read, also the first way to clear the alert
	task automatic read_status();
		@(posedge clk_i);
		#1;
		status_rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		status_rd_o = 1'b0;
	endtask
	// Receive byte at the alert-response address, the second clearing way
	task automatic read_ara();
		@(posedge clk_i);
		#1;
		ara_rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		ara_rd_o = 1'b0;
	endtask
endmodule
`default_nettype wire
